// ---- common/rml_params.svh ----
// Constants for the reset, mode latch and external interrupt pin block.
`ifndef RML_PARAMS_SVH
`define RML_PARAMS_SVH
`define RML_NUM_PINS 4
`define RML_MODE_RESET 4'h0
`define RML_PHASE_RESET 2'h0
`define RML_SYNC_RESET 4'hf
`define RML_EDGE_RESET 4'h0
`define RML_PORT_RESET 4'h0
`endif

// ---- common/rml_pkg.sv ----
// Types shared by the reset, mode latch and external interrupt pin block.
package rml_pkg;
    // Per-pin function after reset.
    typedef enum logic [1:0] {
        RML_FN_IRQ,
        RML_FN_GPIO_IN,
        RML_FN_GPIO_OUT,
        RML_FN_GPIO_OFF
    } rml_fn_t;

    // Per-pin configuration from the core.
    typedef struct packed {
        rml_fn_t fn;
        logic edge_sense;
        logic irq_enable;
        logic gpio_out;
    } rml_pin_cfg_t;

    // Reset sequencing state.
    typedef enum logic [1:0] {
        RML_ST_RESET,
        RML_ST_LATCH,
        RML_ST_RUN
    } rml_state_t;
endpackage : rml_pkg

// ---- design/rml_reset_mode.sv ----
// Reset sequencing, operating mode capture and mode/interrupt pin handling.
// What this block does
// - All four mode pins active low, synchronized first.
// - Pin selects mode in reset, later interrupt.
// - Four pins form 4-bit operating mode.
// - Port bit is input, output or disconnected.
// - Reset holds chip and phase generator.
// - Mode latched when reset is released.
`timescale 1ns/1ns
`include "rml_params.svh"

module rml_reset_mode #(
    parameter int NUM_PINS = `RML_NUM_PINS
) (
    input wire logic core_clk, // Core clock, 125 MHz.
    input wire logic reset, // Asynchronous power-on reset, active high.
    input wire logic reset_pin_n, // Board reset pin, active low, asynchronous.
    input wire logic [3:0] mode_pin_n, // Mode/interrupt pins, one to four, raw.
    input wire rml_pkg::rml_pin_cfg_t [3:0] pin_cfg, // Per-pin function from the core.
    input wire logic [3:0] irq_ack, // Clears a latched edge request.
    output logic chip_reset, // Reset to the rest of the chip.
    output logic [1:0] phase_q, // Internal clock phase generator.
    output logic [3:0] operating_mode_register, // Latched initial mode.
    output logic mode_valid, // Mode has been latched.
    output logic [3:0] ext_int_request, // Masked interrupt requests.
    output logic [3:0] port_h_in, // Port H input values.
    output logic [3:0] port_h_out, // Port H pin drive value.
    output logic [3:0] port_h_oe // Port H output enables.
);

    // Every vector below is four wide, so any other pin count is refused.
    if (NUM_PINS != 4)
    begin : g_pin_count_check
        $error("rml_reset_mode supports exactly four mode pins");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers.

    logic [3:0] pin_meta_q;
    logic [3:0] pin_sync_q;
    logic [3:0] pin_prev_q;
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            pin_meta_q <= `RML_SYNC_RESET;
            pin_sync_q <= `RML_SYNC_RESET;
            pin_prev_q <= `RML_SYNC_RESET;
        end
        else
        begin
            pin_meta_q <= mode_pin_n;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    // The reset pin is synchronised too, so its release lands cleanly in the clock domain.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= reset_pin_n;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencing.

    rml_pkg::rml_state_t state_q;

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q <= rml_pkg::RML_ST_RESET;
        end
        else if (!rst_sync_q)
        begin
            state_q <= rml_pkg::RML_ST_RESET;
        end
        else
        begin
            case (state_q)
                rml_pkg::RML_ST_RESET: state_q <= rml_pkg::RML_ST_LATCH;
                rml_pkg::RML_ST_LATCH: state_q <= rml_pkg::RML_ST_RUN;
                rml_pkg::RML_ST_RUN: state_q <= rml_pkg::RML_ST_RUN;
                default: state_q <= rml_pkg::RML_ST_RESET;
            endcase
        end
    end

    assign chip_reset = (state_q != rml_pkg::RML_ST_RUN);

    // phase generator cleared
    // The state register enters reset one clock after the synchronised pin falls.
    // Looking at the pin as well keeps the phase at zero on that very edge.
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            phase_q <= `RML_PHASE_RESET;
        end
        else if (chip_reset || !rst_sync_q)
        begin
            phase_q <= `RML_PHASE_RESET;
        end
        else
        begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            operating_mode_register <= `RML_MODE_RESET;
            mode_valid <= 1'b0;
        end
        else if (state_q == rml_pkg::RML_ST_RESET && rst_sync_q)
        begin
            // Bit 0 is pin one; pins are active low, so a grounded pin reads 1.
            operating_mode_register <= ~pin_sync_q;
            mode_valid <= 1'b1;
        end
        else if (!rst_sync_q)
        begin
            mode_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupts and port H.

    logic [3:0] edge_q;

    // Tells whether a pin is handed to the interrupt logic.
    function automatic logic pin_is_irq(rml_pkg::rml_pin_cfg_t cfg);
        return cfg.fn == rml_pkg::RML_FN_IRQ;
    endfunction : pin_is_irq

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            edge_q <= `RML_EDGE_RESET;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                // A new falling edge wins over a same-cycle acknowledge.
                if (chip_reset || !pin_is_irq(pin_cfg[i]))
                begin
                    edge_q[i] <= 1'b0;
                end
                else if (pin_prev_q[i] && !pin_sync_q[i])
                begin
                    edge_q[i] <= 1'b1;
                end
                else if (irq_ack[i])
                begin
                    edge_q[i] <= 1'b0;
                end
            end
        end
    end

    // level or edge request
    // The level path reads the synchronised pin, so a request trails the pin by two clocks.
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            ext_int_request[i] = !chip_reset && pin_is_irq(pin_cfg[i]) &&
                pin_cfg[i].irq_enable && (pin_cfg[i].edge_sense ? edge_q[i] : !pin_sync_q[i]);
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            port_h_in <= `RML_PORT_RESET;
            port_h_out <= `RML_PORT_RESET;
            port_h_oe <= `RML_PORT_RESET;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                port_h_in[i] <= (pin_cfg[i].fn == rml_pkg::RML_FN_GPIO_IN) ? pin_sync_q[i] : 1'b0;
                port_h_out[i] <= pin_cfg[i].gpio_out;
                port_h_oe[i] <= !chip_reset && pin_cfg[i].fn == rml_pkg::RML_FN_GPIO_OUT;
            end
        end
    end

endmodule : rml_reset_mode

// ---- testbench/rml_board_model.sv ----
// Board side: reset source and mode strap and interrupt pin drivers.
`timescale 1ns/1ns
module rml_board_model (
    input wire logic core_clk, // Clock.
    input wire logic hold, // Reset request.
    input wire logic [3:0] lvl, // Pin levels.
    output logic reset_pin_n, // Board reset.
    output logic [3:0] mode_pin_n // Pins.
);
    initial
    begin
        reset_pin_n = 1'h0;
        mode_pin_n = 4'hf;
    end
    always @(posedge core_clk)
    begin
        reset_pin_n <= #1 !hold;
        mode_pin_n <= #1 lvl;
    end
endmodule : rml_board_model

// ---- testbench/rml_checker.sv ----
// Concurrent checks on the reset, mode latch and interrupt pin block.
`timescale 1ns/1ns
module rml_checker (
    input wire logic core_clk, // Clock.
    input wire logic reset, // Reset.
    input wire logic reset_pin_n, // Board reset.
    input wire logic [3:0] mode_pin_n, // Pins.
    input wire rml_pkg::rml_pin_cfg_t [3:0] pin_cfg, // Config.
    input wire logic chip_reset, // Chip reset.
    input wire logic [1:0] phase_q, // Phase.
    input wire logic [3:0] operating_mode_register, // Mode.
    input wire logic mode_valid, // Mode latched.
    input wire logic [3:0] ext_int_request, // Requests.
    input wire logic [3:0] port_h_oe // Enables.
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    a_phase_in_reset: assert property (chip_reset |-> phase_q == 2'h0)
        else $error("phase moved in reset");
    a_irq_quiet_reset: assert property (chip_reset |-> ext_int_request == 4'h0)
        else $error("request in reset");
    a_release_delay: assert property ($rose(reset_pin_n) && chip_reset |-> ##3 $rose(mode_valid))
        else $error("mode latch late");
    a_mode_value: assert property ($rose(mode_valid) |-> operating_mode_register == ~$past(mode_pin_n, 3))
        else $error("wrong mode latched");
    a_run_after_mode: assert property ($rose(mode_valid) |=> $fell(chip_reset))
        else $error("chip reset not released");
    a_mode_holds: assert property (mode_valid && $past(mode_valid) |-> $stable(operating_mode_register))
        else $error("mode changed");
    a_oe_out_only: assert property (port_h_oe[2] |-> $past(pin_cfg[2].fn) == rml_pkg::RML_FN_GPIO_OUT)
        else $error("drive without output");
    a_mask_gate: assert property (ext_int_request[3] |-> pin_cfg[3].irq_enable)
        else $error("masked request seen");
    a_level_sense: assert property ($fell(mode_pin_n[3]) && !chip_reset && pin_cfg[3].irq_enable
        && pin_cfg[3].fn == rml_pkg::RML_FN_IRQ |-> ##[2:3] ext_int_request[3])
        else $error("level request missing");
    c_boot: cover property ($rose(mode_valid));
    c_edge: cover property (ext_int_request[0]);
    c_drive: cover property (port_h_oe[2]);
endmodule : rml_checker
bind rml_reset_mode rml_checker chk_u (.core_clk(core_clk), .reset(reset), .reset_pin_n(reset_pin_n),
    .mode_pin_n(mode_pin_n), .pin_cfg(pin_cfg), .chip_reset(chip_reset), .phase_q(phase_q),
    .operating_mode_register(operating_mode_register), .mode_valid(mode_valid),
    .ext_int_request(ext_int_request), .port_h_oe(port_h_oe));

// ---- testbench/test_reset_mode_latch_irq_pins.sv ----
// Self-checking bench for the reset, mode latch and interrupt pin block.
`timescale 1ns/1ns
module test_reset_mode_latch_irq_pins;
    logic core_clk = 0, reset = 1, hold = 1, rst_n;
    logic [3:0] lvl = 4'hf, pins, ack = 4'h0, mode, req, hin, hout, hoe;
    logic [1:0] ph;
    logic crst, mval;
    rml_pkg::rml_pin_cfg_t [3:0] cfg = '0;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    rml_board_model bm_u (.core_clk(core_clk), .hold(hold), .lvl(lvl), .reset_pin_n(rst_n), .mode_pin_n(pins));
    rml_reset_mode dut_u (.core_clk(core_clk), .reset(reset), .reset_pin_n(rst_n), .mode_pin_n(pins),
        .pin_cfg(cfg), .irq_ack(ack), .chip_reset(crst), .phase_q(ph), .operating_mode_register(mode),
        .mode_valid(mval), .ext_int_request(req), .port_h_in(hin), .port_h_out(hout), .port_h_oe(hoe));
    initial
    begin
        forever #4 core_clk = !core_clk;
    end
    task automatic step(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step
    task automatic chk(string n, logic [3:0] s, logic [3:0] e);
        cmp_count++;
        if (s !== e)
        begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask : chk
    task automatic t_boot(logic [3:0] m);
        hold = 1;
        lvl = ~m;
        step(4);
        chk("chip_reset", {3'h0, crst}, 4'h1);
        chk("phase", {2'h0, ph}, 4'h0);
        chk("valid_in_reset", {3'h0, mval}, 4'h0);
        hold = 0;
        step(8);
        chk("mode", mode, m);
        chk("mode_valid", {3'h0, mval}, 4'h1);
        chk("chip_run", {3'h0, crst}, 4'h0);
        lvl = 4'hf;
        step(3);
        chk("mode_hold", mode, m);
    endtask : t_boot
    task automatic t_irq;
        cfg[0] = '{rml_pkg::RML_FN_IRQ, 1'h1, 1'h1, 1'h0};
        step(2);
        lvl[0] = 0;
        step(5);
        lvl[0] = 1;
        step(4);
        chk("edge_req", req, 4'h1);
        ack[0] = 1;
        step(1);
        ack[0] = 0;
        lvl[3] = 0;
        step(5);
        chk("masked", req, 4'h0);
        lvl[3] = 1;
        cfg[3] = '{rml_pkg::RML_FN_IRQ, 1'h0, 1'h1, 1'h0};
        step(3);
        lvl[3] = 0;
        step(5);
        chk("level_req", req, 4'h8);
        lvl[3] = 1;
        step(5);
        chk("level_off", req, 4'h0);
    endtask : t_irq
    task automatic t_gpio;
        cfg[2] = '{rml_pkg::RML_FN_GPIO_OUT, 1'h0, 1'h1, 1'h1};
        step(3);
        chk("oe_out", hoe & hout, 4'h4);
        cfg[2].fn = rml_pkg::RML_FN_GPIO_IN;
        step(2);
        chk("port_in_high", hin, 4'h4);
        lvl[2] = 0;
        step(5);
        chk("oe_in", hoe | req, 4'h0);
        chk("port_in_low", hin, 4'h0);
        cfg[2].fn = rml_pkg::RML_FN_GPIO_OFF;
        step(3);
        chk("oe_off", hoe, 4'h0);
    endtask : t_gpio
    task automatic give_verdict;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            num_errors++;
            give_verdict();
        end
    end
    initial
    begin
        step(2);
        reset = 0;
        for (int i = 0; i < 16; i++)
            t_boot(i[3:0]);
        t_irq();
        t_gpio();
        give_verdict();
    end
endmodule : test_reset_mode_latch_irq_pins
